// ### hdl/fllc_pkg.sv
// Constants, register map and state codes for the loop configuration block
package fllc_pkg;
   // Register byte addresses
   localparam logic [15:0] FLLC_A_CTRL1 = 16'h1c00;
   localparam logic [15:0] FLLC_A_CTRL2 = 16'h1c04;
   localparam logic [15:0] FLLC_A_CTRL3 = 16'h1c08;
   localparam logic [15:0] FLLC_A_CTRL4 = 16'h1c0c;
   localparam logic [15:0] FLLC_A_GAIN  = 16'h1c10;
   localparam logic [15:0] FLLC_A_STAT  = 16'h1c14;
   // Control 1 bits
   localparam int          FLLC_B_EN     = 0;
   localparam int          FLLC_B_HOLD   = 1;
   localparam int          FLLC_B_COMMIT = 2;
   localparam logic [1:0]  FLLC_RST_C1   = 2'h2;
   // Control 2 fields
   localparam int          FLLC_B_LTHR  = 28;
   localparam int          FLLC_B_RDET  = 21;
   localparam int          FLLC_B_PDIV  = 16;
   localparam int          FLLC_B_SRC   = 12;
   localparam int          FLLC_B_N     = 0;
   // Control 4 fields
   localparam int          FLLC_B_FBDIV = 16;
   localparam int          FLLC_B_SYSX2 = 8;
   localparam int          FLLC_B_GDIV  = 0;
   // Reference source codes
   localparam logic [3:0]  FLLC_SRC_MCLK = 4'h0;
   localparam logic [3:0]  FLLC_SRC_PDM  = 4'h5;
   localparam logic [3:0]  FLLC_SRC_SP1  = 4'h8;
   localparam logic [3:0]  FLLC_SRC_SP2  = 4'h9;
   // Staged words: control 2, control 3, control 4, gain
   localparam int          FLLC_NSTG = 4;
   localparam logic [31:0] FLLC_MASK [FLLC_NSTG] =
      '{32'hf863f3ff, 32'hffffffff, 32'h01ff017f, 32'h0033ffff};
   localparam logic [31:0] FLLC_RST  [FLLC_NSTG] =
      '{32'h88200004, 32'h00000000, 32'h00010001, 32'h00300000};
   // Reference loss timeout
   localparam int          FLLC_CLK_NS     = 40;
   localparam int          FLLC_REF_TO_NS  = 10000;
   localparam int          FLLC_REF_TO_CYC = FLLC_REF_TO_NS / FLLC_CLK_NS;
   typedef enum logic [3:0] {
      FLLC_OFF   = 4'b0001,
      FLLC_TRACK = 4'b0010,
      FLLC_HOLD  = 4'b0100,
      FLLC_FREE  = 4'b1000
   } fllc_state_e;
endpackage

// ### hdl/fllc_top.sv
// Loop configuration, reference path, staging and state control
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module fllc_top
   import fllc_pkg::*;
(
   // Clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rstn,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [15:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // Reference and loop clock levels
   input  wire logic        i_master_clock_input,
   input  wire logic        i_pdm_reference_clock,
   input  wire logic [1:0]  i_serial_port_bit_clock,
   input  wire logic        i_loop_clk,
   // Loop control outputs
   output logic             o_ref_divided,
   output logic             o_ref_lost,
   output logic             o_ref_lost_evt,
   output logic      [3:0]  o_loop_state,
   output logic             o_feedback_active,
   output logic      [18:0] o_fb_product,
   output logic      [15:0] o_frac_num,
   output logic      [15:0] o_frac_den,
   output logic      [31:0] o_gain_cfg,
   output logic             o_system_clock_double,
   output logic             o_gpio_clk
);
   logic [31:0] pend_q [FLLC_NSTG];
   logic [31:0] act_q  [FLLC_NSTG];
   logic [1:0]  c1_q;
   fllc_state_e state_q, state_d;
   logic        ref_q, loop_q;
   logic [2:0]  pdiv_cnt_q;
   logic [8:0]  idle_q;
   logic [6:0]  gcnt_q;

   function automatic int stg_index(input logic [15:0] a);
      unique case (a)
         FLLC_A_CTRL2: stg_index = 0;
         FLLC_A_CTRL3: stg_index = 1;
         FLLC_A_CTRL4: stg_index = 2;
         FLLC_A_GAIN:  stg_index = 3;
         default:      stg_index = -1;
      endcase
   endfunction

   // APB decode; one wait-free access phase after setup
   wire        setup   = i_psel & ~i_penable;
   wire        acc     = i_psel & i_penable & o_pready;
   wire        wr      = acc & i_pwrite;
   wire        hit_c1  = i_paddr == FLLC_A_CTRL1;
   wire        hit_st  = i_paddr == FLLC_A_STAT;
   wire        mapped  = hit_c1 | hit_st | (stg_index(i_paddr) >= 0);
   wire        en      = c1_q[FLLC_B_EN];
   wire        commit  = wr & hit_c1 & i_pwdata[FLLC_B_COMMIT];
   wire [31:0] stat_rd = {24'h0, o_ref_lost, o_feedback_active, 2'h0, o_loop_state};
   wire [31:0] c1_rd   = {30'h0, c1_q};
   wire [31:0] rd_mux  = hit_c1 ? c1_rd : hit_st ? stat_rd :
                         mapped ? pend_q[stg_index(i_paddr)] : 32'h0;

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0;
         c1_q      <= FLLC_RST_C1;
      end else begin
         o_pready  <= setup;
         o_pslverr <= setup & ~mapped;
         o_prdata  <= setup ? rd_mux : 32'h0;
         if (wr & hit_c1)
            c1_q <= i_pwdata[1:0];
      end
   end

   // Staging: pending words always follow writes, active words follow writes while disabled and commit while enabled
   genvar g;
   for (g = 0; g < FLLC_NSTG; g++) begin : g_stg
      wire whit = wr & (stg_index(i_paddr) == g);
      always_ff @(posedge i_mclk or negedge i_rstn) begin
         if (!i_rstn) begin
            pend_q[g] <= FLLC_RST[g];
            act_q[g]  <= FLLC_RST[g];
         end else begin
            if (whit)
               pend_q[g] <= i_pwdata & FLLC_MASK[g];
            if (whit & ~en)
               act_q[g] <= i_pwdata & FLLC_MASK[g];
            else if (commit & en)
               act_q[g] <= pend_q[g];
         end
      end
   end

   // Reference selection, reserved codes give no reference
   wire [3:0] src  = act_q[0][FLLC_B_SRC +: 4];
   wire [1:0] pdiv = act_q[0][FLLC_B_PDIV +: 2];
   wire       rdet = act_q[0][FLLC_B_RDET];
   wire       ref_sel = (src == FLLC_SRC_MCLK) ? i_master_clock_input :
                        (src == FLLC_SRC_PDM)  ? i_pdm_reference_clock :
                        (src == FLLC_SRC_SP1)  ? i_serial_port_bit_clock[0] :
                        (src == FLLC_SRC_SP2)  ? i_serial_port_bit_clock[1] : 1'b0;
   wire       ref_edge = ref_sel & ~ref_q;
   wire       div_d = (pdiv == 2'h0) ? ref_sel : pdiv_cnt_q[pdiv - 2'h1];
   // Detection watches raw edges, so the predivider cannot stretch the timeout
   wire       idle_max = idle_q == 9'(FLLC_REF_TO_CYC);
   // A returning edge wins over a saturated idle count, else the flag sticks
   wire       lost_d = rdet & en & ~ref_edge & (idle_max | o_ref_lost);

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         ref_q          <= 1'b0;
         pdiv_cnt_q     <= 3'h0;
         o_ref_divided  <= 1'b0;
         idle_q         <= 9'h0;
         o_ref_lost     <= 1'b0;
         o_ref_lost_evt <= 1'b0;
      end else begin
         ref_q          <= ref_sel;
         pdiv_cnt_q     <= pdiv_cnt_q + 3'(ref_edge);
         o_ref_divided  <= div_d;
         idle_q         <= ref_edge ? 9'h0 : idle_max ? idle_q : idle_q + 9'h1;
         o_ref_lost     <= lost_d;
         o_ref_lost_evt <= lost_d & ~o_ref_lost;
      end
   end

   // Loop state: lost reference free-runs regardless of hold
   always_comb begin
      if (!en)
         state_d = FLLC_OFF;
      else if (o_ref_lost)
         state_d = FLLC_FREE;
      else if (c1_q[FLLC_B_HOLD])
         state_d = FLLC_HOLD;
      else
         state_d = FLLC_TRACK;
   end

   // GPIO divider on the loop clock
   wire [6:0] gdiv   = act_q[2][FLLC_B_GDIV +: 7];
   wire       gedge  = i_loop_clk & ~loop_q;
   wire       gwrap  = gcnt_q >= gdiv - 7'h1;
   wire [6:0] ghalf  = 7'((8'(gdiv) + 8'h1) >> 1);
   wire       gpio_d = (gdiv <= 7'h1) ? i_loop_clk : (gcnt_q < ghalf);
   wire [18:0] prod  = 19'(act_q[0][FLLC_B_N +: 10] * act_q[2][FLLC_B_FBDIV +: 9]);

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q           <= FLLC_OFF;
         o_feedback_active <= 1'b0;
         loop_q            <= 1'b0;
         gcnt_q            <= 7'h0;
         o_gpio_clk        <= 1'b0;
         o_fb_product      <= 19'h0;
         o_frac_num        <= 16'h0;
         o_frac_den        <= 16'h0;
         o_gain_cfg        <= 32'h0;
         o_system_clock_double   <= 1'b0;
      end else begin
         state_q           <= state_d;
         o_feedback_active <= state_d == FLLC_TRACK;
         loop_q            <= i_loop_clk;
         if (gedge)
            gcnt_q <= gwrap ? 7'h0 : gcnt_q + 7'h1;
         o_gpio_clk        <= gpio_d;
         o_fb_product      <= prod;
         o_frac_num        <= act_q[1][15:0];
         o_frac_den        <= act_q[1][31:16];
         o_gain_cfg        <= act_q[3];
         o_system_clock_double   <= act_q[2][FLLC_B_SYSX2];
      end
   end
   assign o_loop_state = state_q;

   // Checks
   wire c2_wr = wr & (i_paddr == FLLC_A_CTRL2);
   a_ref_mclk_path: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (src == FLLC_SRC_MCLK && pdiv == 2'h0) |=> o_ref_divided == $past(i_master_clock_input))
      else $error("master reference not routed");
   a_prediv_edge: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      ($rose(o_ref_divided) && $past(pdiv) != 2'h0 && $stable(pdiv) && $past(pdiv, 2) == $past(pdiv))
      |-> $past(ref_edge, 2))
      else $error("divided reference rose without reference edge");
   a_lost_event: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (rdet && en && idle_max && !o_ref_lost && !ref_edge) |=> o_ref_lost && o_ref_lost_evt ##1 !o_ref_lost_evt)
      else $error("reference loss event wrong");
   a_system_clock_rate: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      $changed(act_q[2][FLLC_B_SYSX2]) |=> o_system_clock_double == $past(act_q[2][FLLC_B_SYSX2]))
      else $error("system clock rate not applied");
   a_gpio_unity: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (gdiv == 7'h1) |=> o_gpio_clk == $past(i_loop_clk))
      else $error("unity gpio ratio not passed through");
   a_ratio_product: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (commit && en) |=> ##1 o_fb_product == 19'($past(pend_q[0][9:0], 2) * $past(pend_q[2][24:16], 2)))
      else $error("feedback product wrong after commit");
   a_frac_fields: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (wr && !en && i_paddr == FLLC_A_CTRL3) |=> ##1 {o_frac_den, o_frac_num} == $past(i_pwdata, 2))
      else $error("fraction fields not applied");
   a_stage_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (c2_wr && en) |=> act_q[0] == $past(act_q[0]))
      else $error("enabled write applied without commit");
   a_direct_write: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (c2_wr && !en) |=> act_q[0] == pend_q[0])
      else $error("disabled write not applied");
   a_hold_feedback: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      o_feedback_active == (o_loop_state == FLLC_TRACK))
      else $error("feedback active outside tracking");
   a_lost_freerun: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (en && o_ref_lost && !(wr && hit_c1)) |=> o_loop_state == FLLC_FREE)
      else $error("no free-run on lost reference");
   a_commit_zero: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (acc && !i_pwrite && hit_c1) |-> !o_prdata[FLLC_B_COMMIT])
      else $error("commit bit read back nonzero");
   c_commit: cover property (@(posedge i_mclk) disable iff (!i_rstn) commit && en);
   c_freerun: cover property (@(posedge i_mclk) disable iff (!i_rstn) o_loop_state == FLLC_FREE);
   c_relock: cover property (@(posedge i_mclk) disable iff (!i_rstn)
      o_loop_state == FLLC_FREE ##1 o_loop_state == FLLC_TRACK);
endmodule // fllc_top
`default_nettype wire

// ### testbench/fllc_testbench.sv
// Self-checking bench for the loop configuration block
`timescale 1ns/10ps
`default_nettype none
module testbench
   import fllc_pkg::*;
;
   logic        i_mclk    = 1'b0;
   logic        i_rstn    = 1'b0;
   logic        i_psel    = 1'b0;
   logic        i_penable = 1'b0;
   logic        i_pwrite  = 1'b0;
   logic [15:0] i_paddr   = 16'h0000;
   logic [31:0] i_pwdata  = 32'h00000000;
   logic [4:0]  refs      = 5'h00;
   logic [31:0] o_prdata, o_gain_cfg, r, fr;
   logic        o_pready, o_pslverr, o_ref_divided, o_ref_lost, o_ref_lost_evt;
   logic        o_feedback_active, o_system_clock_double, o_gpio_clk, e, sx, rd_q, gp_q;
   logic [3:0]  o_loop_state;
   logic [18:0] o_fb_product;
   logic [15:0] o_frac_num, o_frac_den, rnd;
   logic [9:0]  nv, n2;
   logic [8:0]  fb;
   logic [6:0]  gr;
   int          err_count, check_count, rd_rises, gp_rises, evt_cnt, b;
   localparam logic [3:0] SRC_TAB [4] = '{FLLC_SRC_MCLK, FLLC_SRC_PDM, FLLC_SRC_SP1, FLLC_SRC_SP2};
   localparam logic [31:0] C2 = 32'h88200000;
   // High-range integer-mode gain presets, delay and modulator bits kept set
   localparam logic [31:0] GAIN_HI = 32'h00310f12;

   fllc_top fllc_top_inst (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr), .i_master_clock_input(refs[0]),
      .i_pdm_reference_clock(refs[1]), .i_serial_port_bit_clock(refs[3:2]), .i_loop_clk(refs[4]),
      .o_ref_divided(o_ref_divided), .o_ref_lost(o_ref_lost), .o_ref_lost_evt(o_ref_lost_evt),
      .o_loop_state(o_loop_state), .o_feedback_active(o_feedback_active), .o_fb_product(o_fb_product),
      .o_frac_num(o_frac_num), .o_frac_den(o_frac_den), .o_gain_cfg(o_gain_cfg),
      .o_system_clock_double(o_system_clock_double), .o_gpio_clk(o_gpio_clk));

   always #20 i_mclk = ~i_mclk;

   // Edge counters on divided outputs; phase independent over whole periods
   always @(posedge i_mclk) begin
      rd_q <= o_ref_divided;
      gp_q <= o_gpio_clk;
      if (o_ref_divided === 1'b1 && rd_q === 1'b0) rd_rises++;
      if (o_gpio_clk === 1'b1 && gp_q === 1'b0) gp_rises++;
      if (o_ref_lost_evt === 1'b1) evt_cnt++;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic report_and_stop;
      if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      check_count++;
      if (g !== x) begin
         err_count++;
         $display("MISMATCH %0t value %h expected %h", $time, g, x);
      end
   endtask

   task automatic chk_cnt(input int g, input int x);
      check_count++;
      if (g != x) begin
         err_count++;
         $display("MISMATCH %0t count %0d expected %0d", $time, g, x);
      end
   endtask

   // Master holds request until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_mclk);
      i_psel    <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite  <= w;
      i_paddr   <= a;
      i_pwdata  <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_mclk);
         n++;
      end while (o_pready !== 1'b1);
      chk_cnt(n, 1);
      r = o_prdata;
      e = o_pslverr;
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 32'h0);
      chk(r, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask

   task automatic settle;
      repeat (2) @(posedge i_mclk);
      @(negedge i_mclk);
   endtask

   task automatic edges(input int sel, input int n);
      for (int i = 0; i < 2 * n; i++) begin
         @(posedge i_mclk);
         refs[sel] <= ~refs[sel];
         @(posedge i_mclk);
      end
   endtask

   task automatic run_cnt(input int sel, input int n, input int x_rd, input int x_gp);
      int b_rd, b_gp;
      @(negedge i_mclk);
      b_rd = rd_rises;
      b_gp = gp_rises;
      edges(sel, n);
      settle();
      chk_cnt(rd_rises - b_rd, x_rd);
      chk_cnt(gp_rises - b_gp, x_gp);
   endtask

   initial begin
      rnd = 16'hd110;
      repeat (6) @(posedge i_mclk);
      i_rstn <= 1'b1;
      rd_chk(FLLC_A_CTRL1, 32'h2, 1'b0);
      for (int i = 0; i < FLLC_NSTG; i++) rd_chk(FLLC_A_CTRL2 + 16'(4 * i), FLLC_RST[i], 1'b0);
      rd_chk(FLLC_A_STAT, 32'h1, 1'b0);
      rd_chk(16'h1c18, 32'h0, 1'b1);
      // Loop disabled: fields apply without commit, corner values first
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         nv = (k == 0) ? 10'h3ff : rnd[9:0];
         rnd = lfsr(rnd);
         fb = (k == 0) ? 9'h1ff : (rnd[8:0] | 9'h1);
         sx = rnd[15];
         fr = {rnd, lfsr(rnd)};
         apb(1'b1, FLLC_A_CTRL2, C2 | 32'(nv));
         apb(1'b1, FLLC_A_CTRL4, {7'h0, fb, 7'h0, sx, 8'h01});
         apb(1'b1, FLLC_A_CTRL3, fr);
         settle();
         chk({13'h0, o_fb_product}, 32'(nv) * 32'(fb));
         chk({o_frac_den, o_frac_num}, fr);
         chk({31'h0, o_system_clock_double}, {31'h0, sx});
      end
      // Each source code with its own predivider ratio, 3 down to 0; the next source must not leak
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, FLLC_A_CTRL2, C2 | (32'(3 - s) << 16) | (32'(SRC_TAB[s]) << 12) | 32'h4);
         settle();
         run_cnt(s, 64, 64 >> (3 - s), 0);
         run_cnt((s + 1) % 4, 16, 0, 0);
      end
      // Divider ratio bounds and a random one
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         gr = (k == 0) ? 7'd1 : (k == 1) ? 7'd2 : (k == 2) ? 7'd127 : (rnd[6:0] | 7'h1);
         apb(1'b1, FLLC_A_CTRL4, 32'h00010000 | 32'(gr));
         settle();
         run_cnt(4, 2 * int'(gr), 0, 2);
      end
      apb(1'b1, FLLC_A_CTRL2, C2 | 32'd5);
      apb(1'b1, FLLC_A_GAIN, GAIN_HI);
      apb(1'b1, FLLC_A_CTRL1, 32'h3);
      edges(0, 4);
      @(negedge i_mclk);
      chk({28'h0, o_loop_state}, 32'h4);
      chk({31'h0, o_feedback_active}, 32'h0);
      chk(o_gain_cfg, GAIN_HI & FLLC_MASK[3]);
      // Staged while enabled: old value stands until commit
      rnd = lfsr(rnd);
      n2 = {rnd[9:3], 3'h2};
      apb(1'b1, FLLC_A_CTRL2, C2 | 32'(n2));
      settle();
      chk({13'h0, o_fb_product}, 32'd5);
      rd_chk(FLLC_A_CTRL2, C2 | 32'(n2), 1'b0);
      apb(1'b1, FLLC_A_CTRL1, 32'h7);
      settle();
      chk({13'h0, o_fb_product}, 32'(n2));
      rd_chk(FLLC_A_CTRL1, 32'h3, 1'b0);
      apb(1'b1, FLLC_A_CTRL1, 32'h1);
      edges(0, 2);
      @(negedge i_mclk);
      chk({28'h0, o_loop_state}, 32'h2);
      chk({31'h0, o_feedback_active}, 32'h1);
      b = evt_cnt;
      repeat (260) @(posedge i_mclk);
      @(negedge i_mclk);
      chk({31'h0, o_ref_lost}, 32'h1);
      chk({28'h0, o_loop_state}, 32'h8);
      chk_cnt(evt_cnt - b, 1);
      edges(0, 2);
      @(negedge i_mclk);
      chk({31'h0, o_ref_lost}, 32'h0);
      chk({28'h0, o_loop_state}, 32'h2);
      // Reset in mid-run brings back the reset configuration
      @(posedge i_mclk);
      i_rstn <= 1'b0;
      repeat (2) @(posedge i_mclk);
      @(negedge i_mclk);
      chk({28'h0, o_loop_state}, 32'h1);
      chk({13'h0, o_fb_product}, 32'h0);
      @(posedge i_mclk);
      i_rstn <= 1'b1;
      settle();
      chk({13'h0, o_fb_product}, 32'(FLLC_RST[0][FLLC_B_N +: 10]) * 32'(FLLC_RST[2][FLLC_B_FBDIV +: 9]));
      rd_chk(FLLC_A_CTRL1, 32'h2, 1'b0);
      report_and_stop();
   end

   // Whole run needs under 6000 cycles
   initial begin
      repeat (20000) @(posedge i_mclk);
      err_count++;
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
